/* verilog/iao_pkg.sv */
// shared types and constants for the increment / or execution datapath
// assumes an 8-bit core with a 128-entry file register space
package iao_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int F_ADDR_MAX = 127;

  // destination select encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // reset values, increment step and zero compare value
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;

  // cycles taken by a skip that fires: its own plus the discarded one
  localparam int SKIP_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INCREMENT_REGISTER,
    OP_INCREMENT_SKIP_IF_ZERO,
    OP_OR_LITERAL_INTO_ACCUMULATOR,
    OP_OR_ACCUMULATOR_WITH_REGISTER
  } iao_op_e;

  typedef enum logic {
    SEQ_RUN,
    SEQ_SKIP
  } iao_seq_e;

  // one decoded instruction with its file operand already fetched
  typedef struct packed {
    logic valid;
    iao_op_e op;
    logic [ADDR_W-1:0] f_addr;
    logic dest;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] f_data;
  } iao_req_s;

  // write-back to the file register array
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } iao_wr_s;

endpackage

/* verilog/iao_alu.sv */
// combinational result path for the four instructions
// assumes operands are stable in the cycle the request is presented
`timescale 1ns/10ps
`default_nettype none

module iao_alu (
  // operands
  input wire iao_pkg::iao_op_e op,
  input wire logic [iao_pkg::DATA_W-1:0] acc,
  input wire logic [iao_pkg::DATA_W-1:0] f_data,
  input wire logic [iao_pkg::DATA_W-1:0] literal,
  // results
  output logic [iao_pkg::DATA_W-1:0] result,
  output logic result_zero,
  output logic updates_zero,
  output logic is_inc_skip
);

  wire logic [iao_pkg::DATA_W-1:0] inc_sum;
  wire logic [iao_pkg::DATA_W-1:0] or_lit;
  wire logic [iao_pkg::DATA_W-1:0] or_reg;

  // sum wraps at 8 bits, so 8'hff + 1 gives zero
  assign inc_sum = f_data + iao_pkg::INC_STEP;
  assign or_lit = acc | literal;
  assign or_reg = acc | f_data;

  assign result = (op == iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR) ? or_lit :
                  (op == iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER) ? or_reg :
                  inc_sum;
  assign result_zero = (result == iao_pkg::ZERO_VAL);
  // skip variant leaves the status flags alone
  assign updates_zero = (op == iao_pkg::OP_INCREMENT_REGISTER) ||
                        (op == iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR) ||
                        (op == iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER);
  assign is_inc_skip = (op == iao_pkg::OP_INCREMENT_SKIP_IF_ZERO);

endmodule

`default_nettype wire

/* verilog/iao_exec.sv */
// execution datapath: increment, increment-and-skip, or-literal, or-register
// assumes decoder presents one instruction per valid cycle with file data fetched
//
// Overview of operation
// - file address 0..127, destination bit: 0 to accumulator, 1 to file
// - increment adds one to file operand, writes destination, updates zero flag
// - increment-and-skip writes the sum to destination, leaves zero flag untouched
// - zero skip result discards next instruction as nop, two cycles total
// - or-literal ors 8-bit literal into accumulator, updates zero flag
// - or-register ors accumulator with file operand into destination, updates zero
`timescale 1ns/10ps
`default_nettype none

module iao_exec #(
  parameter int ADDR_W = iao_pkg::ADDR_W,
  parameter int DATA_W = iao_pkg::DATA_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // decoded instruction in
  input wire iao_pkg::iao_req_s req,
  // file register write-back
  output iao_pkg::iao_wr_s file_wr,
  // core state
  output logic [iao_pkg::DATA_W-1:0] acc_out,
  output logic zero_flag,
  // skip sequencing
  output logic skip_pending,
  output logic squash_pulse
);

  generate
    if (ADDR_W != iao_pkg::ADDR_W || DATA_W != iao_pkg::DATA_W) begin : g_bad
      $error("iao_exec supports only a 7-bit address and 8-bit data");
    end
  endgenerate

  logic [iao_pkg::DATA_W-1:0] acc_reg;
  logic [iao_pkg::DATA_W-1:0] acc_next;
  logic zero_reg;
  logic zero_next;
  iao_pkg::iao_wr_s wr_reg;
  iao_pkg::iao_wr_s wr_next;
  iao_pkg::iao_seq_e seq_reg;
  iao_pkg::iao_seq_e seq_next;
  logic squash_reg;
  logic squash_next;

  wire logic [iao_pkg::DATA_W-1:0] alu_result;
  wire logic alu_zero;
  wire logic alu_upd_zero;
  wire logic alu_inc_skip;
  wire logic is_real_op;
  wire logic discard;
  wire logic execute;
  wire logic to_file;
  wire logic to_acc;
  wire logic skip_hit;

  iao_alu u_alu (
    .op(req.op),
    .acc(acc_reg),
    .f_data(req.f_data),
    .literal(req.literal),
    .result(alu_result),
    .result_zero(alu_zero),
    .updates_zero(alu_upd_zero),
    .is_inc_skip(alu_inc_skip)
  );

  assign is_real_op = req.valid && (req.op != iao_pkg::OP_NONE);
  // a pending skip eats the next presented instruction, whatever it is
  assign discard = req.valid && (seq_reg == iao_pkg::SEQ_SKIP);
  assign execute = is_real_op && (seq_reg == iao_pkg::SEQ_RUN);
  // or-literal always lands in the accumulator, dest bit ignored
  assign to_file = execute && (req.dest == iao_pkg::DEST_FILE) &&
                   (req.op != iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR);
  assign to_acc = execute && !to_file;
  assign skip_hit = execute && alu_inc_skip && alu_zero;

  assign acc_next = to_acc ? alu_result : acc_reg;
  assign zero_next = (execute && alu_upd_zero) ? alu_zero : zero_reg;
  assign wr_next = '{we: to_file, addr: req.f_addr, data: alu_result};
  assign squash_next = discard;

  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      iao_pkg::SEQ_RUN: begin
        if (skip_hit) begin
          seq_next = iao_pkg::SEQ_SKIP;
        end
      end
      iao_pkg::SEQ_SKIP: begin
        if (discard) begin
          seq_next = iao_pkg::SEQ_RUN;
        end
      end
      default: begin
        seq_next = iao_pkg::SEQ_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_reg <= iao_pkg::ACC_RST;
      zero_reg <= iao_pkg::ZERO_RST;
      wr_reg <= '0;
      seq_reg <= iao_pkg::SEQ_RUN;
      squash_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      zero_reg <= zero_next;
      wr_reg <= wr_next;
      seq_reg <= seq_next;
      squash_reg <= squash_next;
    end
  end

  assign acc_out = acc_reg;
  assign zero_flag = zero_reg;
  assign file_wr = wr_reg;
  assign skip_pending = (seq_reg == iao_pkg::SEQ_SKIP);
  assign squash_pulse = squash_reg;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  wire logic exec_inc;
  wire logic exec_skip;
  wire logic exec_orl;
  wire logic exec_orr;
  assign exec_inc = execute && (req.op == iao_pkg::OP_INCREMENT_REGISTER);
  assign exec_skip = execute && (req.op == iao_pkg::OP_INCREMENT_SKIP_IF_ZERO);
  assign exec_orl = execute && (req.op == iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR);
  assign exec_orr = execute && (req.op == iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER);

  sequence s_skip_zero;
    exec_skip && (req.f_data == 8'hff);
  endsequence

  sequence s_discard_taken;
    skip_pending && req.valid;
  endsequence

  sequence s_squash_shown;
    squash_pulse && !skip_pending && !file_wr.we;
  endsequence

  chk_dest_file_write: assert property (
    (execute && !exec_orl && req.dest == iao_pkg::DEST_FILE) |=>
      (file_wr.we && file_wr.addr == $past(req.f_addr) && acc_out == $past(acc_out)))
    else $error("file destination not written back");

  chk_inc_value: assert property (
    (exec_inc && req.dest == iao_pkg::DEST_ACC) |=>
      (acc_out == 8'($past(req.f_data) + 8'h01) && !file_wr.we))
    else $error("increment result wrong");

  chk_skip_keeps_zero: assert property (
    exec_skip |=> (zero_flag == $past(zero_flag)))
    else $error("increment-and-skip changed zero flag");

  chk_skip_fires: assert property (
    s_skip_zero |=> skip_pending)
    else $error("zero increment-and-skip did not arm skip");

  chk_skip_nonzero: assert property (
    (exec_skip && req.f_data != 8'hff) |=> !skip_pending)
    else $error("nonzero increment-and-skip armed skip");

  chk_discard_noeffect: assert property (
    s_discard_taken |=>
      (squash_pulse && !skip_pending && !file_wr.we &&
       acc_out == $past(acc_out) && zero_flag == $past(zero_flag)))
    else $error("discarded instruction had an effect");

  chk_orl_value: assert property (
    exec_orl |=> (acc_out == ($past(acc_out) | $past(req.literal)) && !file_wr.we))
    else $error("or-literal result wrong");

  chk_orr_value: assert property (
    (exec_orr && req.dest == iao_pkg::DEST_FILE) |=>
      (file_wr.data == ($past(acc_out) | $past(req.f_data))))
    else $error("or-register result wrong");

  chk_zero_update: assert property (
    (execute && alu_upd_zero) |=> (zero_flag == ($past(alu_result) == 8'h00)))
    else $error("zero flag does not match result");

  chk_squash_once: assert property (
    s_discard_taken |=> s_squash_shown ##1 !squash_pulse)
    else $error("discard not shown by a single squash pulse");

  // the discard waits for a valid cycle, so idle cycles must keep the armed skip
  chk_skip_held: assert property (
    (skip_pending && !req.valid) |=> (skip_pending && !squash_pulse))
    else $error("armed skip dropped during an idle cycle");

  chk_skip_value: assert property (
    exec_skip |=>
      (($past(req.dest) ? file_wr.data : acc_out) == 8'($past(req.f_data) + 8'h01)))
    else $error("increment-and-skip result wrong");

  chk_inc_file: assert property (
    (exec_inc && req.dest == iao_pkg::DEST_FILE) |=>
      (file_wr.we && file_wr.data == 8'($past(req.f_data) + 8'h01)))
    else $error("increment write-back wrong");

  chk_orr_acc: assert property (
    (exec_orr && req.dest == iao_pkg::DEST_ACC) |=>
      (acc_out == ($past(acc_out) | $past(req.f_data)) && !file_wr.we))
    else $error("or-register to accumulator wrong");

  chk_idle_quiet: assert property (
    !req.valid |=>
      (!file_wr.we && !squash_pulse && acc_out == $past(acc_out)))
    else $error("idle cycle changed state");

  chk_zero_kept: assert property (
    !execute |=> (zero_flag == $past(zero_flag)))
    else $error("zero flag moved without an instruction");

endmodule

`default_nettype wire

/* dv/iao_file_model.sv */
// file register array as seen by the decoder, with write forwarding
// assumes one write-back per cycle from the datapath
`timescale 1ns/10ps
`default_nettype none
module iao_file_model (
  // clock
  input wire logic core_clk,
  // write-back and read port
  input wire iao_pkg::iao_wr_s file_wr,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [128];
  logic fwd;
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(8'h80 + i);
  end
  always @(posedge core_clk) begin
    if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
  end
  // write lands one cycle late, so a back-to-back read needs the bypass
  assign fwd = file_wr.we && (file_wr.addr == rd_addr);
  assign rd_data = fwd ? file_wr.data : mem[rd_addr];
endmodule
`default_nettype wire

/* dv/increment_and_or_ops_bench.sv */
// self-checking bench for the increment / or datapath
// assumes the file model supplies the operand of the presented address
`timescale 1ns/10ps
`default_nettype none
module increment_and_or_ops_bench;
  typedef struct packed {
    logic [7:0] acc;
    logic z;
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
    logic skip;
    logic sq;
  } iao_note_s;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic v_in = 1'b0;
  iao_pkg::iao_op_e op_in = iao_pkg::OP_NONE;
  logic [6:0] a_in = 7'h00;
  logic d_in = 1'b0;
  logic [7:0] k_in = 8'h00;
  logic [7:0] f_rd;
  iao_pkg::iao_req_s req;
  iao_pkg::iao_wr_s file_wr;
  logic [7:0] acc_out;
  logic zero_flag, skip_pending, squash_pulse;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 71132;
  int cycles = 0;
  iao_note_s notes [$];
  logic [7:0] m_acc = 8'h00;
  logic m_z = 1'b0;
  logic m_skp = 1'b0;
  logic [7:0] m_f [128];
  logic [31:0] rv;
  always #12.5 core_clk = ~core_clk;
  assign req = '{v_in, op_in, a_in, d_in, k_in, f_rd};
  iao_exec uut (.core_clk(core_clk), .sys_rst(sys_rst), .req(req), .file_wr(file_wr),
    .acc_out(acc_out), .zero_flag(zero_flag), .skip_pending(skip_pending),
    .squash_pulse(squash_pulse));
  iao_file_model fm (.core_clk(core_clk), .file_wr(file_wr), .rd_addr(a_in), .rd_data(f_rd));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_reset;
    cmp("reset acc_out", 8'h00, acc_out);
    cmp("reset zero_flag", 8'h00, {7'h00, zero_flag});
    cmp("reset file_wr.we", 8'h00, {7'h00, file_wr.we});
    cmp("reset skip_pending", 8'h00, {7'h00, skip_pending});
    cmp("reset squash_pulse", 8'h00, {7'h00, squash_pulse});
  endtask
  task automatic issue(input iao_pkg::iao_op_e op, input logic [6:0] a, input logic d,
      input logic [7:0] k);
    iao_note_s n;
    logic [7:0] r;
    logic lit;
    @(negedge core_clk);
    v_in = 1'b1;
    op_in = op;
    a_in = a;
    d_in = d;
    k_in = k;
    lit = (op == iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR);
    n = '{m_acc, m_z, 1'b0, a, 8'h00, 1'b0, 1'b0};
    if (m_skp) begin
      n.sq = 1'b1;
      m_skp = 1'b0;
    end else if (op != iao_pkg::OP_NONE) begin
      r = lit ? (m_acc | k) : (op == iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER) ?
          (m_acc | m_f[a]) : 8'(m_f[a] + 8'h01);
      if (op != iao_pkg::OP_INCREMENT_SKIP_IF_ZERO) m_z = (r == 8'h00);
      else m_skp = (r == 8'h00);
      if (d && !lit) begin
        m_f[a] = r;
        n.we = 1'b1;
        n.data = r;
      end else m_acc = r;
      n.acc = m_acc;
      n.z = m_z;
      n.skip = m_skp;
    end
    notes.push_back(n);
  endtask
  task automatic idle;
    @(negedge core_clk);
    v_in = 1'b0;
  endtask
  // result shows right after the taking edge; look once it has settled
  always @(posedge core_clk) begin : mon
    iao_note_s n;
    logic v;
    v = v_in && !sys_rst;
    #2;
    if (v && notes.size() > 0) begin
      n = notes.pop_front();
      cmp("acc_out", n.acc, acc_out);
      cmp("zero_flag", {7'h00, n.z}, {7'h00, zero_flag});
      cmp("file_wr.we", {7'h00, n.we}, {7'h00, file_wr.we});
      if (n.we) cmp("file_wr.addr", {1'b0, n.addr}, {1'b0, file_wr.addr});
      if (n.we) cmp("file_wr.data", n.data, file_wr.data);
      cmp("skip_pending", {7'h00, n.skip}, {7'h00, skip_pending});
      cmp("squash_pulse", {7'h00, n.sq}, {7'h00, squash_pulse});
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 128; i++) m_f[i] = 8'(8'h80 + i);
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    check_reset();
    $display("test reset done");
    issue(iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b1, 8'h00);
    issue(iao_pkg::OP_INCREMENT_REGISTER, 7'h7f, 1'b1, 8'h00);
    issue(iao_pkg::OP_INCREMENT_REGISTER, 7'h7f, 1'b0, 8'h00);
    issue(iao_pkg::OP_INCREMENT_SKIP_IF_ZERO, 7'h00, 1'b0, 8'h00);
    issue(iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER, 7'h01, 1'b1, 8'h00);
    issue(iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b0, 8'hff);
    issue(iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER, 7'h02, 1'b1, 8'h00);
    issue(iao_pkg::OP_INCREMENT_SKIP_IF_ZERO, 7'h02, 1'b1, 8'h00);
    issue(iao_pkg::OP_INCREMENT_REGISTER, 7'h05, 1'b1, 8'h00);
    issue(iao_pkg::OP_OR_ACCUMULATOR_WITH_REGISTER, 7'h03, 1'b1, 8'h00);
    issue(iao_pkg::OP_INCREMENT_SKIP_IF_ZERO, 7'h03, 1'b0, 8'h00);
    idle();
    issue(iao_pkg::OP_NONE, 7'h00, 1'b0, 8'h00);
    issue(iao_pkg::OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b0, 8'h00);
    $display("test directed done");
    // arm a skip, then reset mid-run: the armed skip must not survive
    issue(iao_pkg::OP_INCREMENT_SKIP_IF_ZERO, 7'h03, 1'b0, 8'h00);
    idle();
    sys_rst = 1'b1;
    m_acc = 8'h00;
    m_z = 1'b0;
    m_skp = 1'b0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    check_reset();
    $display("test mid reset done");
    repeat (300) begin
      rv = $random(seed);
      if (rv[31]) idle();
      issue(iao_pkg::iao_op_e'(3'(rv[10:8] % 3'h5)), rv[6:0], rv[7], rv[23:16]);
    end
    idle();
    repeat (2) @(negedge core_clk);
    cmp("notes left", 8'h00, 8'(notes.size()));
    $display("test random done");
    give_verdict();
  end
endmodule
`default_nettype wire
